// ---- src/cmcr_pkg.sv ----
// package for the cpu mode and configuration register bank
package cmcr_pkg;
  // ****************************************
  // status word high byte layout
  // ****************************************
  localparam int PRIV_BIT = 7; // privilege bit position
  localparam int TRACE_BIT = 6; // trace enable bit position
  localparam int BANK_HI_BIT = 5; // bank select high
  localparam int BANK_LO_BIT = 4; // bank select low
  localparam logic [7:0] USER_WRITE_MASK = 8'h30; // bits user mode may change
  localparam logic [3:0] PRIO_MAX = 4'hf; // blocks all event interrupts
  // ****************************************
  // global configuration layout
  // ****************************************
  localparam int SMALL_ADDR_BIT = 0; // page zero addressing flag
  localparam int COMPAT_BIT = 1; // register overlay mode flag
  localparam int PDIV_LO_BIT = 2; // peripheral clock divider low bit
  localparam logic [7:0] CFG_DEFINED_MASK = 8'h0f; // four defined bits
  localparam logic [7:0] CFG_RESET = 8'h00; // value after reset
  localparam logic [7:0] STATUS_HIGH_RESET = 8'h00; // until vector load
  localparam logic [7:0] STATUS_LOW_RESET = 8'h00; // until vector load
  localparam logic [4:0] COMPAT_WINDOW = 5'h1f; // low 32 bytes overlaid
  localparam logic [1:0] PDIV_4 = 2'h0; // oscillator divided by 4
  localparam logic [1:0] PDIV_16 = 2'h1; // oscillator divided by 16
  localparam logic [1:0] PDIV_64 = 2'h2; // oscillator divided by 64
  localparam logic [6:0] PDIV_CNT_4 = 7'h03; // terminal counts per divide
  localparam logic [6:0] PDIV_CNT_16 = 7'h0f;
  localparam logic [6:0] PDIV_CNT_64 = 7'h3f;

  // ****************************************
  // carriers
  // ****************************************
  // special function register write request from the core
  typedef struct packed {
    logic wr_high; // explicit write of status word high
    logic wr_low; // explicit write of status word low
    logic wr_cfg; // write of global configuration
    logic [7:0] data; // write data
  } cmcr_wr_t;

  // implicit alu flag update
  typedef struct packed {
    logic en; // alu wants to update flags
    logic [7:0] flags; // new low byte
  } cmcr_flag_t;

  // decoded mode outputs
  typedef struct packed {
    logic privileged; // system mode
    logic trace_en; // debug facilities on
    logic [1:0] bank; // active register bank
    logic [3:0] exec_prio; // execution priority
    logic small_addr; // 16-bit page zero mode
    logic compat; // register overlay mode
    logic [1:0] pdiv; // peripheral clock select
  } cmcr_mode_t;

  // whole state of the block
  typedef struct packed {
    logic [7:0] status_word_high;
    logic [7:0] status_word_low;
    logic [7:0] global_configuration;
    logic [6:0] pdiv_cnt;
    logic periph_tick;
    logic event_irq_take;
    logic [23:0] code_addr;
    logic [15:0] ovl_ptr;
    logic ovl_hit;
    logic [4:0] ovl_reg_sel;
    logic [23:0] push_addr;
    logic push_two_words;
    cmcr_mode_t mode;
  } cmcr_state_t;
endpackage : cmcr_pkg

// ---- src/cmcr_regs.sv ----
// cpu operating mode and global configuration register bank
`timescale 1ns/1ps
module cmcr_regs (
  input wire logic i_core_clk, // core clock, 20 mhz
  input wire logic i_reset, // asynchronous, active high
  input wire cmcr_pkg::cmcr_wr_t i_sfr_wr, // register writes
  input wire cmcr_pkg::cmcr_flag_t i_alu_flags, // implicit flag updates
  input wire logic i_vector_load, // reset vector word is present
  input wire logic [15:0] i_vector_status, // initial status word from vector
  input wire logic [3:0] i_pending_prio, // highest pending event priority
  input wire logic i_pending_valid, // an event interrupt is pending
  input wire logic [23:0] i_next_code_addr, // code address from sequencer
  input wire logic [15:0] i_data_addr, // data address within segment
  input wire logic i_indirect, // indirect reference in progress
  input wire logic i_indirect_r1, // reference through r1, else r0
  input wire logic [15:0] i_reg0_word, // active bank r0 contents
  input wire logic [23:0] i_call_addr, // return address to push
  output logic [7:0] o_status_word_high, // status word high byte
  output logic [7:0] o_status_word_low, // status word low byte
  output logic [7:0] o_global_configuration, // configuration readback
  output cmcr_pkg::cmcr_mode_t o_mode, // decoded mode
  output logic o_periph_tick, // peripheral timing clock pulse
  output logic o_event_irq_take, // start event interrupt sequence
  output logic [23:0] o_code_addr, // code address, truncated in page zero
  output logic [15:0] o_ovl_ptr, // indirect pointer value
  output logic o_ovl_hit, // data access hits register overlay
  output logic [4:0] o_ovl_reg_sel, // overlay byte: bank, reg, byte
  output logic [23:0] o_push_addr, // address as pushed on stack
  output logic o_push_two_words // push 24 bits, else one 16-bit word
);
  import cmcr_pkg::*;

  // ****************************************
  // state
  // ****************************************
  cmcr_state_t st; // registered state
  cmcr_state_t next_st; // next state
  logic [7:0] wr_mask; // bits this write may change
  logic [7:0] cfg_new; // configuration in effect this cycle
  logic [6:0] div_term; // divider terminal count

  // ****************************************
  // next state logic
  // ****************************************
  always_comb begin
    next_st = st;
    // in the high byte user mode may touch only the bank bits; system mode everything
    if (st.status_word_high[PRIV_BIT]) begin
      wr_mask = 8'hff;
    end else begin
      wr_mask = USER_WRITE_MASK;
    end
    // implicit flag update only when no explicit status byte write is taken;
    // any explicit write to either byte discards all implicit flag updates
    if (i_alu_flags.en && !i_sfr_wr.wr_low && !i_sfr_wr.wr_high) begin
      next_st.status_word_low = i_alu_flags.flags;
    end
    if (i_sfr_wr.wr_low) begin
      next_st.status_word_low = i_sfr_wr.data;
    end
    if (i_sfr_wr.wr_high) begin
      // low byte left alone here on purpose
      next_st.status_word_high = (st.status_word_high & ~wr_mask) |
                                 (i_sfr_wr.data & wr_mask);
    end
    // configuration: only defined bits stored, reserved read zero
    if (i_sfr_wr.wr_cfg) begin
      next_st.global_configuration = i_sfr_wr.data & CFG_DEFINED_MASK;
    end
    // vector load wins over every status byte write and flag update, it is the reset exception
    if (i_vector_load) begin
      next_st.status_word_high = i_vector_status[15:8];
      next_st.status_word_low = i_vector_status[7:0];
    end
    cfg_new = st.global_configuration;
    // decoded mode follows the registered bytes
    next_st.mode.privileged = next_st.status_word_high[PRIV_BIT];
    next_st.mode.trace_en = next_st.status_word_high[TRACE_BIT];
    next_st.mode.bank = next_st.status_word_high[BANK_HI_BIT:BANK_LO_BIT];
    next_st.mode.exec_prio = next_st.status_word_high[3:0];
    next_st.mode.small_addr = next_st.global_configuration[SMALL_ADDR_BIT];
    next_st.mode.compat = next_st.global_configuration[COMPAT_BIT];
    next_st.mode.pdiv = next_st.global_configuration[PDIV_LO_BIT +: 2];
    // event interrupt: strictly higher than current priority; 15 never passes
    next_st.event_irq_take = i_pending_valid &&
                             (i_pending_prio > st.status_word_high[3:0]) &&
                             (st.status_word_high[3:0] != PRIO_MAX);
    // peripheral timing divider
    unique case (cfg_new[PDIV_LO_BIT +: 2])
      PDIV_4: div_term = PDIV_CNT_4;
      PDIV_16: div_term = PDIV_CNT_16;
      PDIV_64: div_term = PDIV_CNT_64;
      default: div_term = PDIV_CNT_4; // reserved code: keep a clock running
    endcase
    if (st.pdiv_cnt >= div_term) begin
      next_st.pdiv_cnt = 7'h00;
      next_st.periph_tick = 1'b1;
    end else begin
      next_st.pdiv_cnt = st.pdiv_cnt + 7'h01;
      next_st.periph_tick = 1'b0;
    end
    // code address truncated one cycle after page zero is in effect
    if (cfg_new[SMALL_ADDR_BIT]) begin
      next_st.code_addr = {8'h00, i_next_code_addr[15:0]};
      next_st.push_addr = {8'h00, i_call_addr[15:0]};
      next_st.push_two_words = 1'b0;
    end else begin
      next_st.code_addr = i_next_code_addr;
      next_st.push_addr = i_call_addr;
      next_st.push_two_words = 1'b1;
    end
    // indirect pointer: only r0/r1 in compat mode change, rest untouched
    if (cfg_new[COMPAT_BIT] && i_indirect && !i_indirect_r1) begin
      next_st.ovl_ptr = {8'h00, i_reg0_word[7:0]};
    end else if (cfg_new[COMPAT_BIT] && i_indirect && i_indirect_r1) begin
      next_st.ovl_ptr = {8'h00, i_reg0_word[15:8]};
    end else begin
      next_st.ovl_ptr = i_data_addr;
    end
    // overlay: bottom 32 bytes of any segment map onto banks 0..3 r0..r3
    next_st.ovl_hit = cfg_new[COMPAT_BIT] &&
                      (i_data_addr[15:5] == 11'h000);
    next_st.ovl_reg_sel = i_data_addr[4:0] & COMPAT_WINDOW;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      st <= '0;
      st.status_word_high <= STATUS_HIGH_RESET;
      st.status_word_low <= STATUS_LOW_RESET;
      st.global_configuration <= CFG_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs, all straight from the state flops
  // ****************************************
  assign o_status_word_high = st.status_word_high;
  assign o_status_word_low = st.status_word_low;
  assign o_global_configuration = st.global_configuration;
  assign o_mode = st.mode;
  assign o_periph_tick = st.periph_tick;
  assign o_event_irq_take = st.event_irq_take;
  assign o_code_addr = st.code_addr;
  assign o_ovl_ptr = st.ovl_ptr;
  assign o_ovl_hit = st.ovl_hit;
  assign o_ovl_reg_sel = st.ovl_reg_sel;
  assign o_push_addr = st.push_addr;
  assign o_push_two_words = st.push_two_words;
endmodule : cmcr_regs

// ---- test/cmcr_regs_props.sv ----
// assertion checker for the mode and configuration register bank
`timescale 1ns/1ps
module cmcr_regs_props (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire cmcr_pkg::cmcr_wr_t i_sfr_wr,
  input wire logic i_vector_load,
  input wire logic [15:0] i_vector_status,
  input wire logic [3:0] i_pending_prio,
  input wire logic i_pending_valid,
  input wire logic [23:0] i_next_code_addr,
  input wire logic i_indirect,
  input wire logic i_indirect_r1,
  input wire logic [15:0] i_reg0_word,
  input wire logic [7:0] o_status_word_high,
  input wire logic [7:0] o_status_word_low,
  input wire logic [7:0] o_global_configuration,
  input wire cmcr_pkg::cmcr_mode_t o_mode,
  input wire logic o_event_irq_take,
  input wire logic [23:0] o_code_addr,
  input wire logic [15:0] o_ovl_ptr,
  input wire logic o_push_two_words
);
  import cmcr_pkg::*;
  // ****************************************
  // properties, all on the core clock
  // ****************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  wire hw = i_sfr_wr.wr_high && !i_vector_load; // explicit high byte write
  property p_user; hw && !o_mode.privileged |=> o_status_word_high == {$past(o_status_word_high[7:6]), $past(i_sfr_wr.data[5:4]), $past(o_status_word_high[3:0])}; endproperty
  a_user: assert property (p_user) else $error("user write changed a protected bit");
  property p_keep; hw && !i_sfr_wr.wr_low |=> $stable(o_status_word_low); endproperty
  a_keep: assert property (p_keep) else $error("high byte write moved low byte");
  property p_vec; i_vector_load |=> {o_status_word_high, o_status_word_low} == $past(i_vector_status); endproperty
  a_vec: assert property (p_vec) else $error("vector word not loaded");
  property p_irq; i_pending_valid && i_pending_prio > o_mode.exec_prio && o_mode.exec_prio != PRIO_MAX |=> o_event_irq_take; endproperty
  a_irq: assert property (p_irq) else $error("event interrupt not taken");
  property p_map; o_mode == {o_status_word_high, o_global_configuration[0], o_global_configuration[1], o_global_configuration[3:2]} && o_global_configuration[7:4] == 4'h0; endproperty
  a_map: assert property (p_map) else $error("mode outputs disagree with bytes");
  property p_page0; o_mode.small_addr |=> o_code_addr == {8'h00, $past(i_next_code_addr[15:0])} && !o_push_two_words; endproperty
  a_page0: assert property (p_page0) else $error("page zero address not truncated");
  property p_large; !o_mode.small_addr |=> o_code_addr == $past(i_next_code_addr) && o_push_two_words; endproperty
  a_large: assert property (p_large) else $error("large model address wrong");
  property p_ptr; o_mode.compat && i_indirect |=> o_ovl_ptr == {8'h00, $past(i_indirect_r1) ? $past(i_reg0_word[15:8]) : $past(i_reg0_word[7:0])}; endproperty
  a_ptr: assert property (p_ptr) else $error("indirect pointer wrong");
  c_user: cover property (hw && !o_mode.privileged);
  c_take: cover property (o_event_irq_take);
  c_ptr: cover property (o_mode.compat && i_indirect && i_indirect_r1);
endmodule : cmcr_regs_props
bind cmcr_regs cmcr_regs_props i_props (.i_core_clk(i_core_clk), .i_reset(i_reset),
  .i_sfr_wr(i_sfr_wr), .i_vector_load(i_vector_load), .i_vector_status(i_vector_status),
  .i_pending_prio(i_pending_prio), .i_pending_valid(i_pending_valid), .i_indirect(i_indirect),
  .i_next_code_addr(i_next_code_addr), .i_indirect_r1(i_indirect_r1), .o_mode(o_mode),
  .i_reg0_word(i_reg0_word), .o_status_word_high(o_status_word_high), .o_ovl_ptr(o_ovl_ptr),
  .o_status_word_low(o_status_word_low), .o_global_configuration(o_global_configuration),
  .o_event_irq_take(o_event_irq_take), .o_code_addr(o_code_addr),
  .o_push_two_words(o_push_two_words));

// ---- test/tb_cmcr_regs.sv ----
// self-checking bench for the mode and configuration register bank
`timescale 1ns/1ps
module tb_cmcr_regs;
  import cmcr_pkg::*;
  // ****************************************
  // stimulus, dut and checks
  // ****************************************
  logic clk, rst = 1, vl = 0, pv = 0, ind = 0, r1 = 0, tick, take, hit, p2;
  logic [15:0] vs = 0, da = 0, r0w = 0, ptr;
  logic [3:0] pp = 0;
  logic [23:0] nca = 0, ca = 0, cao, pao;
  logic [7:0] swh, swl, gcfg;
  logic [4:0] sel;
  cmcr_wr_t wr = '0;
  cmcr_flag_t af = '0;
  cmcr_mode_t md;
  int failures = 0, samples_checked = 0;
  cmcr_regs i_dut (.i_core_clk(clk), .i_reset(rst), .i_sfr_wr(wr), .i_alu_flags(af),
    .i_vector_load(vl), .i_vector_status(vs), .i_pending_prio(pp), .i_pending_valid(pv),
    .i_next_code_addr(nca), .i_data_addr(da), .i_indirect(ind), .i_indirect_r1(r1),
    .i_reg0_word(r0w), .i_call_addr(ca), .o_status_word_high(swh), .o_status_word_low(swl),
    .o_global_configuration(gcfg), .o_mode(md), .o_periph_tick(tick), .o_event_irq_take(take),
    .o_code_addr(cao), .o_ovl_ptr(ptr), .o_ovl_hit(hit), .o_ovl_reg_sel(sel), .o_push_addr(pao),
    .o_push_two_words(p2));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // one-cycle strobe; k 0 high, 1 low, 2 config
  task automatic wreg(input int k, input logic [7:0] d);
    @(negedge clk);
    wr = '{wr_high: k == 0, wr_low: k == 1, wr_cfg: k == 2, data: d};
    @(negedge clk);
    wr = '0;
  endtask : wreg
  // status byte write with an implicit flag update in the same cycle
  task automatic wflag(input int k, input logic [7:0] d);
    @(negedge clk);
    af = '{en: 1'b1, flags: 8'h00};
    wr = '{wr_high: k == 0, wr_low: k == 1, wr_cfg: 1'b0, data: d};
    @(negedge clk);
    af = '0;
    wr = '0;
  endtask : wflag
  task automatic vec(input logic [15:0] w);
    @(negedge clk);
    vl = 1;
    vs = w;
    @(negedge clk);
    vl = 0;
  endtask : vec
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic t_mode;
    chk("cfg_rst", gcfg, 8'h00);
    vec(16'h8f5a);
    chk("vec", {swh, swl}, 16'h8f5a);
    for (int b = 0; b < 4; b++) begin
      wreg(0, {2'b11, b[1:0], 4'h3});
      chk("bank", md.bank, b[1:0]);
      chk("trace", md.trace_en, 1'b1);
    end
    wflag(1, 8'h81);
    chk("low_expl", swl, 8'h81);
    wflag(0, 8'h85);
    chk("low_kept", swl, 8'h81);
  endtask : t_mode
  task automatic t_irq;
    pv = 1;
    pp = 4'h6;
    @(negedge clk);
    chk("take", take, 1'b1);
    pp = 4'h5;
    @(negedge clk);
    chk("take_eq", take, 1'b0);
    wreg(0, 8'h8f);
    pp = 4'hf;
    @(negedge clk);
    chk("take_15", take, 1'b0);
    pv = 0;
    wreg(0, 8'h05);
    chk("priv_off", md.privileged, 1'b0);
    wreg(0, 8'hfa);
    chk("user_wr", swh, 8'h35);
    vec(16'h8f00);
  endtask : t_irq
  task automatic t_div;
    int n;
    for (int d = 0; d < 3; d++) begin
      wreg(2, {4'h0, d[1:0], 2'b00});
      repeat (70) @(negedge clk);
      n = 0;
      repeat (128) begin
        @(negedge clk);
        n += tick;
      end
      chk("ticks", n, 128 >> (2 * d + 2));
    end
  endtask : t_div
  task automatic t_addr;
    nca = 24'h123456;
    ca = 24'h123456;
    r0w = 16'hab12;
    ind = 1;
    da = 16'h001f;
    wreg(2, 8'h02);
    @(negedge clk);
    chk("ptr_r0", ptr, 16'h0012);
    chk("hit", {hit, sel}, 6'h3f);
    chk("ca_cm", cao, 24'h123456);
    r1 = 1;
    da = 16'h0020;
    @(negedge clk);
    chk("ptr_r1", {hit, ptr}, 17'h000ab);
    ind = 0;
    for (int m = 1; m >= 0; m--) begin
      wreg(2, m[7:0]);
      @(negedge clk);
      chk("ca", cao, m ? 24'h003456 : 24'h123456);
      chk("push", {p2, pao}, m ? 25'h0003456 : 25'h1123456);
    end
  endtask : t_addr
  initial begin
    repeat (3) @(negedge clk);
    rst = 0;
    @(negedge clk);
    t_mode();
    t_irq();
    t_div();
    t_addr();
    test_done();
  end
  // watchdog, far beyond the roughly 640 cycles the run needs
  initial begin
    #(50 * 4000);
    failures++;
    test_done();
  end
endmodule : tb_cmcr_regs
